//--- dcs_defines.svh
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// frame header
`define DCS_RW_BIT 31
`define DCS_ID_MSB 30
`define DCS_ID_LSB 26
`define DCS_ID_CFG 5'h08
`define DCS_ID_STAT 5'h09

// configuration word: channel c occupies [CFG_TOP - 6c -: 6]
`define DCS_CFG_TOP 23
`define DCS_CFG_W 24
`define DCS_CFG_RST 24'hffffff
// width of one channel lane in both words
`define DCS_LANE_W 6

// status word: channel c occupies [STAT_TOP - 6c -: 6]
`define DCS_STAT_TOP 25
`define DCS_ENL_BIT 1
`define DCS_RBL_BIT 0
`define DCS_STAT_RST 26'h0000003

// retry interval is this many pwm periods per retry step
`define DCS_RETRY_MULT 4
`define DCS_RETRY_CNT_W 6

`endif

//--- dcs_pkg.sv
package dcs_pkg;

  // one channel of the configuration word, msb first
  typedef struct packed {
    logic [1:0] battery_short_threshold;
    logic [3:0] battery_short_retry_count;
  } dcs_chan_cfg_t;

  // one channel of the status word, msb first
  typedef struct packed {
    logic ground_short_fault;
    logic gate_off_test_done;
    logic battery_short_fault;
    logic battery_short_test_done;
    logic open_load_gate_off_fault;
    logic open_load_gate_on_fault;
  } dcs_chan_flags_t;

  // one received frame
  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } dcs_frame_t;

endpackage : dcs_pkg

//--- dcs_diag_msgs.sv
`include "dcs_defines.svh"

module dcs_diag_msgs #(
  parameter int CH_COUNT = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // decoded frame from the serial port
  input wire dcs_pkg::dcs_frame_t frame_in,
  // response word for the next frame
  output logic resp_valid,
  output logic [31:0] resp_word,
  // device pins, asynchronous
  input wire logic enable_pin,
  input wire logic reset_n_pin,
  // one-cycle events from the diagnostic circuits
  input wire dcs_pkg::dcs_chan_flags_t [CH_COUNT-1:0] diag_event,
  input wire logic pwm_period_tick,
  // configuration to the diagnostic circuits
  output dcs_pkg::dcs_chan_cfg_t [CH_COUNT-1:0] chan_cfg,
  // one-cycle retry request per channel
  output logic [CH_COUNT-1:0] retry_pulse,
  // pin latches as seen by the fault logic
  output logic enable_pin_latch,
  output logic reset_pin_latch
);

  // the frame format carries exactly four channels
  if (CH_COUNT != 4)
  begin : g_bad_count
    $error("dcs_diag_msgs: CH_COUNT must be 4");
  end

  function automatic logic [`DCS_RETRY_CNT_W-1:0] retry_len(input logic [3:0] v);
    logic [`DCS_RETRY_CNT_W-1:0] n;
    n = `DCS_RETRY_CNT_W'(v) * `DCS_RETRY_CNT_W'(`DCS_RETRY_MULT);
    return (v == 4'h0) ? `DCS_RETRY_CNT_W'(1) : n;
  endfunction : retry_len

  // frame puts channel 0 in the top lane, packed arrays put index 0 at the bottom
  function automatic logic [`DCS_CFG_W-1:0] lane_swap(input logic [`DCS_CFG_W-1:0] x);
    logic [`DCS_CFG_W-1:0] y;
    y = '0;
    for (int i = 0; i < 4; i++)
    begin
      y[`DCS_LANE_W*i +: `DCS_LANE_W] = x[`DCS_CFG_W-`DCS_LANE_W*(i+1) +: `DCS_LANE_W];
    end
    return y;
  endfunction : lane_swap

  ////////////////////////////////////////////////////////////////////////////////
  // frame decode

  logic [4:0] frame_id;
  logic frame_wr;
  logic cfg_hit;
  logic cfg_write;
  logic stat_rd;

  assign frame_id = frame_in.word[`DCS_ID_MSB:`DCS_ID_LSB];
  assign frame_wr = frame_in.word[`DCS_RW_BIT];
  assign cfg_hit = frame_in.valid && (frame_id == `DCS_ID_CFG);
  assign cfg_write = cfg_hit && frame_wr;
  // r/w bit is don't-care here
  assign stat_rd = frame_in.valid && (frame_id == `DCS_ID_STAT);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration store

  logic [`DCS_CFG_W-1:0] cfg_q;
  logic [`DCS_CFG_W-1:0] cfg_d;

  // bits 25:24 of a sent frame are unused and never stored
  assign cfg_d = cfg_write ? frame_in.word[`DCS_CFG_W-1:0] : cfg_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cfg_q <= `DCS_CFG_RST;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  assign chan_cfg = lane_swap(cfg_q);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and latches

  logic en_s1_q;
  logic en_s2_q;
  logic en_prev_q;
  logic rb_s1_q;
  logic rb_s2_q;
  logic enl_q;
  logic rbl_q;
  logic en_fall;
  logic enl_d;
  logic rbl_d;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      en_s1_q <= 1'b1;
      en_s2_q <= 1'b1;
      en_prev_q <= 1'b1;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end
    else
    begin
      en_s1_q <= enable_pin;
      en_s2_q <= en_s1_q;
      en_prev_q <= en_s2_q;
      rb_s1_q <= reset_n_pin;
      rb_s2_q <= rb_s1_q;
    end
  end

  assign en_fall = en_prev_q && !en_s2_q;
  // a new falling edge beats a clearing read in the same cycle
  assign enl_d = en_fall || (enl_q && !(stat_rd && en_s2_q));
  // reset pin held low keeps its latch set through any read
  assign rbl_d = !rb_s2_q || (rbl_q && !stat_rd);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      enl_q <= 1'b1;
      rbl_q <= 1'b1;
    end
    else
    begin
      enl_q <= enl_d;
      rbl_q <= rbl_d;
    end
  end

  assign enable_pin_latch = enl_q;
  assign reset_pin_latch = rbl_q;

  ////////////////////////////////////////////////////////////////////////////////
  // sticky channel flags, cleared by a status read

  dcs_pkg::dcs_chan_flags_t [CH_COUNT-1:0] flags_q;
  dcs_pkg::dcs_chan_flags_t [CH_COUNT-1:0] flags_d;

  // set wins over the read clear, so no event is lost
  assign flags_d = diag_event | (stat_rd ? '0 : flags_q);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      flags_q <= '0;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // response words

  logic [31:0] cfg_resp;
  logic [31:0] stat_resp;
  logic [31:0] resp_d;

  // response carries the value after any write in the same frame
  assign cfg_resp = {1'b0, `DCS_ID_CFG, 2'b00, cfg_d};
  // swap so channel 0 lands at 25:20 down to channel 3 at 7:2
  assign stat_resp = {1'b0, `DCS_ID_STAT, lane_swap(flags_q), enl_q, rbl_q};
  assign resp_d = stat_rd ? stat_resp : (cfg_hit ? cfg_resp : resp_word);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      resp_valid <= 1'b0;
      resp_word <= 32'h00000000;
    end
    else
    begin
      resp_valid <= cfg_hit || stat_rd;
      resp_word <= resp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // battery short retry timers, counted in pwm periods

  logic [CH_COUNT-1:0][`DCS_RETRY_CNT_W-1:0] rcnt_q;
  logic [CH_COUNT-1:0] ract_q;
  logic [CH_COUNT-1:0] sb_start;
  logic [CH_COUNT-1:0] r_done;

  for (genvar c = 0; c < CH_COUNT; c++)
  begin : g_retry
    assign sb_start[c] = diag_event[c].battery_short_fault;
    assign r_done[c] = ract_q[c] && pwm_period_tick && (rcnt_q[c] == `DCS_RETRY_CNT_W'(1));
  end

  // a fresh fault restarts the interval from full length
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rcnt_q <= '0;
      ract_q <= '0;
      retry_pulse <= '0;
    end
    else
    begin
      for (int c = 0; c < CH_COUNT; c++)
      begin
        if (sb_start[c])
        begin
          rcnt_q[c] <= retry_len(chan_cfg[c].battery_short_retry_count);
          ract_q[c] <= 1'b1;
        end
        else if (r_done[c])
        begin
          ract_q[c] <= 1'b0;
        end
        else if (ract_q[c] && pwm_period_tick)
        begin
          rcnt_q[c] <= rcnt_q[c] - `DCS_RETRY_CNT_W'(1);
        end
      end
      retry_pulse <= r_done & ~sb_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_cfg_write_stores: assert property (
    cfg_write |=> cfg_q == $past(frame_in.word[`DCS_CFG_W-1:0]))
    else $error("config write not stored");

  a_cfg_read_keeps: assert property (
    (cfg_hit && !frame_wr) |=> $stable(cfg_q))
    else $error("config read changed fields");

  a_cfg_resp_frame: assert property (
    cfg_hit && !stat_rd |=> resp_valid && resp_word[31:24] == 8'h20
      && resp_word[23:0] == cfg_q)
    else $error("config response malformed");

  a_stat_read_any: assert property (
    stat_rd |=> resp_valid && resp_word[31:26] == 6'h09)
    else $error("status read not answered");

  a_stat_flag_map: assert property (
    (stat_rd && !$past(stat_rd)) |=> resp_word[25] == $past(flags_q[0].ground_short_fault)
      && resp_word[7] == $past(flags_q[3].ground_short_fault)
      && resp_word[22] == $past(flags_q[0].battery_short_test_done))
    else $error("status flag placement wrong");

  a_flag_sticky: assert property (
    diag_event[2].battery_short_fault |=> flags_q[2].battery_short_fault)
    else $error("fault event lost");

  a_enl_holds: assert property (
    (enl_q && !en_s2_q) |=> enl_q)
    else $error("enable latch dropped while pin low");

  a_enl_clear: assert property (
    (enl_q && en_s2_q && en_prev_q && stat_rd) |=> !enl_q)
    else $error("enable latch not cleared by read");

  a_retry_zero: assert property (
    (sb_start[0] && chan_cfg[0].battery_short_retry_count == 4'h0)
      ##1 (!sb_start[0] && pwm_period_tick) |=> retry_pulse[0])
    else $error("zero retry not one period");

  a_retry_len: assert property (
    sb_start[0] |=> rcnt_q[0] == (($past(chan_cfg[0].battery_short_retry_count) == 4'h0)
      ? `DCS_RETRY_CNT_W'(1)
      : {$past(chan_cfg[0].battery_short_retry_count), 2'b00}))
    else $error("retry length wrong");

endmodule : dcs_diag_msgs

//--- dcs_host_model.sv
module dcs_host_model (
  // clock
  input wire logic mclk,
  // frame out, response back
  output dcs_pkg::dcs_frame_t frame_o,
  input wire logic resp_valid,
  input wire logic [31:0] resp_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial frame_o = '0;
  // entered just after a falling edge; one frame per call
  task automatic xfer(input logic [31:0] w, output logic v, output logic [31:0] r);
    frame_o = {1'b1, w};
    @(posedge mclk);
    @(negedge mclk);
    v = resp_valid;
    r = resp_word;
    // released word inverted so a stale word never matches
    frame_o = {1'b0, ~w};
    // idle cycle so a following call never reassigns frame_o in this time step
    @(negedge mclk);
  endtask : xfer
endmodule : dcs_host_model

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_pin = 1'b1;
  logic pwm_period_tick = 1'b0;
  dcs_pkg::dcs_frame_t frame_in;
  dcs_pkg::dcs_chan_flags_t [3:0] diag_event = '0;
  dcs_pkg::dcs_chan_cfg_t [3:0] chan_cfg;
  logic resp_valid;
  logic [31:0] resp_word;
  logic [3:0] retry_pulse;
  logic enable_pin_latch;
  logic reset_pin_latch;
  logic v;
  logic p;
  logic [31:0] r;
  int miscompares = 0;
  int checks_done = 0;

  always #5 mclk = ~mclk;

  dcs_diag_msgs #(.CH_COUNT(4)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .frame_in(frame_in),
    .resp_valid(resp_valid), .resp_word(resp_word), .enable_pin(enable_pin),
    .reset_n_pin(1'b1), .diag_event(diag_event), .pwm_period_tick(pwm_period_tick),
    .chan_cfg(chan_cfg), .retry_pulse(retry_pulse), .enable_pin_latch(enable_pin_latch),
    .reset_pin_latch(reset_pin_latch));

  dcs_host_model host_u (.mclk(mclk), .frame_o(frame_in), .resp_valid(resp_valid),
    .resp_word(resp_word));

  //////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic req(input logic [31:0] w, input logic [31:0] exp);
    host_u.xfer(w, v, r);
    chk("resp_valid", 32'h1, {31'h0, v});
    chk("resp_word", exp, r);
  endtask : req

  task automatic t_reset;
    req(32'h20123456, 32'h20ffffff);
    chk("chan_cfg", 32'hffffff, {8'h0, chan_cfg});
    chk("reset_pin_latch", 32'h1, {31'h0, reset_pin_latch});
    req(32'h24000000, 32'h24000003);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write;
    req(32'ha35a3c81, 32'h205a3c81);
    chk("chan_cfg", 32'h5a3c81, {8'h0, chan_cfg[0], chan_cfg[1], chan_cfg[2], chan_cfg[3]});
    // unanswered id must stay silent
    host_u.xfer(32'ha8000000, v, r);
    chk("resp_valid", 32'h0, {31'h0, v});
    chk("resp_word", 32'h205a3c81, r);
    $display("test write done");
  endtask : t_write

  task automatic t_flags;
    for (int c = 0; c < 4; c++)
    begin
      diag_event[c] = 6'h3f;
      @(negedge mclk);
      diag_event = '0;
      req(32'ha7ffffff, 32'h24000000 | (32'h3f << (20 - 6 * c)));
    end
    req(32'h24000000, 32'h24000000);
    $display("test flags done");
  endtask : t_flags

  // ticks spaced two cycles apart so a late pulse is still pinned to its tick
  task automatic t_retry(input int c, input int n);
    diag_event[c] = 6'h08;
    @(negedge mclk);
    diag_event = '0;
    for (int i = 0; i < n; i++)
    begin
      pwm_period_tick = 1'b1;
      @(negedge mclk);
      pwm_period_tick = 1'b0;
      p = retry_pulse[c];
      @(negedge mclk);
      p = p | retry_pulse[c];
      chk("retry_pulse", (i == n - 1) ? 32'h1 : 32'h0, {31'h0, p});
    end
    req(32'h24000000, 32'h24000000 | (32'h1 << (23 - 6 * c)));
    $display("test retry done");
  endtask : t_retry

  task automatic t_enable;
    int k;
    enable_pin = 1'b0;
    k = 0;
    while (enable_pin_latch !== 1'b1 && k < 10)
    begin
      @(negedge mclk);
      k++;
    end
    if (enable_pin_latch !== 1'b1)
    begin
      chk("enable_pin_latch", 32'h1, {31'h0, enable_pin_latch});
      stop_test();
    end
    req(32'h24000000, 32'h24000002);
    enable_pin = 1'b1;
    repeat (6) @(negedge mclk);
    req(32'h24000000, 32'h24000002);
    req(32'h24000000, 32'h24000000);
    chk("enable_pin_latch", 32'h0, {31'h0, enable_pin_latch});
    $display("test enable done");
  endtask : t_enable

  initial
  begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_write();
    t_flags();
    req(32'ha0001fff, 32'h20001fff);
    t_retry(0, 1);
    t_retry(1, 4);
    t_enable();
    stop_test();
  end
endmodule : tb_top
